// *** dasp_pkg.sv ***
package dasp_pkg;
    // ****************************************
    // frame shape
    // ****************************************
    localparam int RESULT_BITS   = 13;            // result width
    localparam int CFG_BITS      = 5;             // start + single/diff + 3 channel bits
    localparam int ACQ_HALF      = 3;             // 1.5 clocks of sampling, in half periods
    localparam int CONV_CLOCKS   = 13;            // one clock per result bit
    localparam int FRAME_CLOCKS  = CFG_BITS + 2 + CONV_CLOCKS; // start-to-lsb clock count
    localparam logic [12:0] CODE_MAX  = 13'h0fff; // most positive two's complement code
    localparam logic [12:0] CODE_MIN  = 13'h1000; // most negative two's complement code
    localparam logic [12:0] CODE_ZERO = 13'h0000;
    localparam logic [12:0] CODE_ONE  = 13'h0001;
    // ****************************************
    // host timing
    // ****************************************
    localparam int CLK_HZ         = 20_000_000;
    localparam int SCLK_MIN_HZ    = 105_000;      // slowest link clock during conversion
    localparam int SCLK_DIV_MAX   = CLK_HZ / (2 * SCLK_MIN_HZ); // half period, rounded down
    localparam int CS_HIGH_NS     = 475;          // select high time between frames
    localparam int CS_HIGH_CYCLES = (CS_HIGH_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    typedef enum logic [2:0] {
        DASP_IDLE  = 3'b000,
        DASP_SEND  = 3'b001,
        DASP_ACQ   = 3'b011,
        DASP_CONV  = 3'b010,
        DASP_GAP   = 3'b110
    } dasp_host_state_t;
endpackage

// *** dasp_link_if.sv ***
`timescale 1ns/10ps
// ****************************************
// serial link between host and converter
// ****************************************
interface dasp_link_if;
    logic selectShutdownN;
    logic sclk;
    logic sdi;
    logic sdo;
    logic sdoEn;
    logic sdoLine;
    // released output reads as low in the bench
    assign sdoLine = sdoEn ? sdo : 1'b0;
    modport device (input selectShutdownN, input sclk, input sdi, output sdo, output sdoEn);
    modport host   (output selectShutdownN, output sclk, output sdi, input sdoLine);
endinterface

// *** dasp_quantizer.sv ***
`timescale 1ns/10ps
// ****************************************
// saturating two's complement quantizer
// ****************************************
module dasp_quantizer
    import dasp_pkg::*;
#(
    parameter int IN_W = 16
) (
    input  wire logic signed [IN_W-1:0] sampleIn,
    output      logic        [12:0]     codeOut
);
    // refused at elaboration: a narrower input cannot reach both extreme codes
    if (IN_W < RESULT_BITS) begin : gBadWidth
        $error("quantizer input narrower than result");
    end
    // input is signed lsb count already rounded at half lsb
    wire logic overHi = sampleIn > $signed({{(IN_W-12){1'b0}}, 12'hfff});
    wire logic overLo = sampleIn < -$signed({{(IN_W-13){1'b0}}, 13'h1000});
    // clamp rather than wrap at the extremes
    assign codeOut = overHi ? CODE_MAX : (overLo ? CODE_MIN : sampleIn[12:0]);
endmodule

// *** dasp_device.sv ***
`timescale 1ns/10ps
module dasp_device
    import dasp_pkg::*;
(
    input  wire logic              rst,
    dasp_link_if.device            link,
    input  wire logic signed [15:0] analogSample,
    output      logic              singleEnded,
    output      logic [2:0]        channelSel,
    output      logic              sampling,
    output      logic              standby
);
    import dasp_pkg::*;
    // ****************************************
    // rising edge: start bit and config capture
    // ****************************************
    logic [2:0]  riseCnt_r;      // config bits taken after start
    logic        started_r;
    logic [3:0]  cfg_r;
    logic        cfgDone_r;
    logic [12:0] code;
    // select high is the async clear: the frame ends on its own signal
    wire logic frameRst = rst | link.selectShutdownN;
    dasp_quantizer #(.IN_W(16)) quant (.sampleIn(analogSample), .codeOut(code));
    always_ff @(posedge link.sclk or posedge frameRst) begin
        if (frameRst) begin
            started_r <= 1'b0;
            riseCnt_r <= 3'h0;
            cfg_r     <= 4'h0;
            cfgDone_r <= 1'b0;
        end else if (!started_r) begin
            started_r <= link.sdi;            // leading one marks start
        end else if (!cfgDone_r) begin
            cfg_r     <= {cfg_r[2:0], link.sdi};
            riseCnt_r <= riseCnt_r + 3'h1;
            cfgDone_r <= (riseCnt_r == 3'h3);
        end
    end
    // decoded by the time the sampling phase begins
    assign singleEnded = cfg_r[3];
    assign channelSel  = cfg_r[2:0];
    assign standby     = link.selectShutdownN;
    // ****************************************
    // falling edge: acquisition and conversion
    // ****************************************
    logic [1:0]  acqCnt_r;
    logic        holding_r;
    logic [12:0] shift_r;
    logic [3:0]  bitCnt_r;
    logic        sdo_r;
    logic        sdoEn_r;
    wire  logic  acqEnd = cfgDone_r && !holding_r && (acqCnt_r == 2'h1);
    // sampling spans half a clock after last config rise plus one full clock
    always_ff @(negedge link.sclk or posedge frameRst) begin
        if (frameRst) begin
            acqCnt_r  <= 2'h0;
            holding_r <= 1'b0;
            shift_r   <= 13'h0000;
            bitCnt_r  <= 4'h0;
            sdo_r     <= 1'b0;
            sdoEn_r   <= 1'b0;
        end else if (cfgDone_r && !holding_r) begin
            acqCnt_r <= acqCnt_r + 2'h1;
            sdoEn_r  <= 1'b1;                  // null bit driven during sampling
            sdo_r    <= 1'b0;
            if (acqEnd) begin
                holding_r <= 1'b1;             // hold switch opens, code latched
                shift_r   <= code;
            end
        end else if (holding_r && bitCnt_r != 4'(CONV_CLOCKS)) begin
            sdo_r    <= shift_r[12];           // msb (sign) first
            shift_r  <= {shift_r[11:0], 1'b0};
            bitCnt_r <= bitCnt_r + 4'h1;
        end
    end
    assign sampling  = cfgDone_r && !holding_r;
    assign link.sdo   = sdo_r;
    assign link.sdoEn = sdoEn_r;
endmodule

// *** dasp_host.sv ***
`timescale 1ns/10ps
// ****************************************
// host end: makes sclk by dividing clk
// ****************************************
module dasp_host
    import dasp_pkg::*;
#(
    parameter int HALF_DIV = 4
) (
    input  wire logic  clk,
    input  wire logic  rst,
    dasp_link_if.host  link,
    input  wire logic  startReq,
    input  wire logic  singleEnded,
    input  wire logic [2:0] channelSel,
    output      logic  busy,
    output      logic  resultValid,
    output      logic [12:0] result
);
    import dasp_pkg::*;
    // the two-flop sdo synchroniser needs three clocks of half period before a rise
    if (HALF_DIV < 3 || HALF_DIV > SCLK_DIV_MAX) begin : gBadDiv
        $error("sclk divider out of range");
    end
    dasp_host_state_t state_r;
    logic [7:0]  div_r;
    logic        sclk_r;
    logic        cs_r;
    logic [4:0]  clkCnt_r;
    logic [4:0]  txSh_r;
    logic [12:0] rxSh_r;
    logic        sdoS1_r;
    logic        sdoS2_r;
    logic        valid_r;
    logic [12:0] result_r;
    logic [7:0]  gap_r;
    wire logic tick = (div_r == 8'(HALF_DIV - 1));
    wire logic rise = tick && !sclk_r;
    wire logic fall = tick && sclk_r;
    // ****************************************
    // frame sequencer
    // ****************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r  <= DASP_IDLE;
            div_r    <= 8'h00;
            sclk_r   <= 1'b0;
            cs_r     <= 1'b1;
            clkCnt_r <= 5'h00;
            txSh_r   <= 5'h00;
            rxSh_r   <= 13'h0000;
            sdoS1_r  <= 1'b0;
            sdoS2_r  <= 1'b0;
            valid_r  <= 1'b0;
            result_r <= 13'h0000;
            gap_r    <= 8'h00;
        end else begin
            sdoS1_r <= link.sdoLine;
            sdoS2_r <= sdoS1_r;
            valid_r <= 1'b0;
            div_r   <= (tick || state_r == DASP_IDLE || state_r == DASP_GAP) ? 8'h00
                       : div_r + 8'h01;
            case (state_r)
                DASP_IDLE: begin
                    if (startReq) begin
                        cs_r     <= 1'b0;
                        txSh_r   <= {1'b1, singleEnded, channelSel};
                        clkCnt_r <= 5'h00;
                        state_r  <= DASP_SEND;
                    end
                end
                DASP_SEND, DASP_ACQ, DASP_CONV: begin
                    if (tick) sclk_r <= !sclk_r;
                    if (fall) txSh_r <= {txSh_r[3:0], 1'b0}; // valid before next rise
                    if (rise) begin
                        clkCnt_r <= clkCnt_r + 5'h01;
                        // sdo changed on previous fall; synchroniser lag is under half period
                        if (clkCnt_r > 5'(CFG_BITS + 1))
                            rxSh_r <= {rxSh_r[11:0], sdoS2_r}; // msb first
                        if (clkCnt_r == 5'(CFG_BITS)) state_r <= DASP_ACQ;
                        if (clkCnt_r == 5'(CFG_BITS + 2)) state_r <= DASP_CONV;
                        // count holds rises before this one: this is rise twenty, the lsb
                        if (clkCnt_r == 5'(FRAME_CLOCKS - 1)) begin // all 13 supplied
                            result_r <= {rxSh_r[11:0], sdoS2_r};
                            valid_r  <= 1'b1;
                            cs_r     <= 1'b1;
                            gap_r    <= 8'h00;
                            state_r  <= DASP_GAP;
                        end
                    end
                end
                DASP_GAP: begin
                    sclk_r <= 1'b0;
                    gap_r  <= gap_r + 8'h01;
                    if (gap_r == 8'(CS_HIGH_CYCLES)) state_r <= DASP_IDLE;
                end
                default: state_r <= DASP_IDLE;
            endcase
        end
    end
    assign link.selectShutdownN = cs_r;
    assign link.sclk  = sclk_r;
    assign link.sdi   = txSh_r[4];
    assign busy        = (state_r != DASP_IDLE);
    assign resultValid = valid_r;
    assign result      = result_r;
endmodule

// *** dasp_link_checker.sv ***
`timescale 1ns/10ps
// ****
// link checker
// ****
module dasp_link_checker
    import dasp_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic selectShutdownN,
    input wire logic sclk,
    input wire logic sdi,
    input wire logic sdo,
    input wire logic sdoEn
);
    logic [4:0] riseCnt_r;
    logic [4:0] riseCnt_nxt;
    logic       sclk_r;
    localparam logic [4:0] CFG_RISES = 5'(CFG_BITS);
    // rises of the link clock in this frame; select high clears it
    assign riseCnt_nxt = selectShutdownN ? 5'h00 : riseCnt_r + {4'h0, sclk & ~sclk_r};
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            riseCnt_r <= 5'h00;
            sclk_r    <= 1'b0;
        end else begin
            riseCnt_r <= riseCnt_nxt;
            sclk_r    <= sclk;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // rises six and seven carry the null bit
    sequence nullRise;
        $rose(sclk) && (riseCnt_r inside {5'h05, 5'h06});
    endsequence
    sequence sdoMoves;
        !selectShutdownN && !$past(selectShutdownN) && $changed(sdo);
    endsequence
    chk_standby_quiet: assert property (selectShutdownN |-> !sdoEn)
        else $error("device drives sdo while deselected");
    chk_sdo_on_fall: assert property (sdoMoves |-> $fell(sclk))
        else $error("sdo changed away from a falling link clock");
    chk_enable_after_cfg: assert property ($rose(sdoEn) |-> riseCnt_r == CFG_RISES)
        else $error("sdo enabled at wrong rise count");
    chk_null_bit: assert property (nullRise |-> sdoEn && !sdo)
        else $error("null bit missing during acquisition");
    // select rises with the last rise, so a full count is never seen with select low
    chk_frame_length: assert property (!selectShutdownN |-> riseCnt_r < 5'(FRAME_CLOCKS))
        else $error("too many link clocks in one frame");
    chk_select_gap: assert property ($rose(selectShutdownN) |-> selectShutdownN [*8])
        else $error("select gap between frames too short");
    chk_sdi_steady: assert property ($rose(sclk) |-> $stable(sdi))
        else $error("sdi moved with the sampling edge");
    chk_no_early_drive: assert property ($fell(selectShutdownN) |-> !sdoEn [*8])
        else $error("device drove sdo right after select fell");
endmodule

// *** testbench.sv ***
`timescale 1ns/10ps
module testbench;
    import dasp_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic startReq = 1'b0;
    logic hostSe = 1'b0;
    logic [2:0] hostCh = 3'h0;
    logic signed [15:0] analogSample = 16'sh0000;
    localparam int HALF_DIV_TB = 4;
    logic busy, resultValid, devSe, sampling, standby, capSe;
    logic [12:0] result;
    logic [2:0] devCh;
    logic [2:0] capCh;
    int sampCnt = 0;
    int err_total = 0;
    int check_count = 0;
    int riseSeen = 0;
    int samples[9] = '{0, 1, 4095, 4096, -1, -4096, -5000, 1365, 32767};
    dasp_link_if link ();
    dasp_host #(.HALF_DIV(HALF_DIV_TB)) dasp_host_inst (.clk(clk), .rst(rst), .link(link),
        .startReq(startReq), .singleEnded(hostSe), .channelSel(hostCh), .busy(busy),
        .resultValid(resultValid), .result(result));
    dasp_device dasp_device_inst (.rst(rst), .link(link), .analogSample(analogSample),
        .singleEnded(devSe), .channelSel(devCh), .sampling(sampling), .standby(standby));
    dasp_link_checker dasp_link_checker_inst (.clk(clk), .rst(rst),
        .selectShutdownN(link.selectShutdownN), .sclk(link.sclk), .sdi(link.sdi),
        .sdo(link.sdo), .sdoEn(link.sdoEn));
    // ****
    // clock and monitors
    // ****
    always #25 clk = ~clk;
    // decoded config is caught while sampling; select high clears the device copy
    always @(posedge clk) begin
        if (sampling === 1'b1) begin
            sampCnt <= sampCnt + 1;
            capSe   <= devSe;
            capCh   <= devCh;
        end
    end
    always @(posedge link.sclk) riseSeen++;
    task check(input logic [12:0] seen, input logic [12:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task close_out;
        $display("mismatches %0d comparisons %0d", err_total, check_count);
        if (err_total == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // saturating code expected from a rounded lsb count
    function logic [12:0] exp_code(input int s);
        if (s > 4095) return CODE_MAX;
        if (s < -4096) return CODE_MIN;
        return 13'(s);
    endfunction
    // one whole frame; waits for idle so frames may run back to back
    task convert(input logic se, input logic [2:0] ch, input int s);
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 400) begin
            @(posedge clk); #2; n++;
        end
        hostSe = se;
        hostCh = ch;
        analogSample = 16'(s);
        startReq = 1'b1;
        sampCnt = 0;
        capSe = ~se;
        capCh = ~ch;
        riseSeen = 0;
        @(posedge clk);
        #2;
        startReq = 1'b0;
        check({12'h000, busy}, 13'h0001);
        while (resultValid !== 1'b1 && n < 800) begin
            @(posedge clk);
            #2;
            n++;
        end
        check({12'h000, resultValid}, 13'h0001);
        check(result, exp_code(s));
        check({12'h000, capSe}, {12'h000, se});
        check({10'h000, capCh}, {10'h000, ch});
        check(13'(sampCnt), 13'(ACQ_HALF * HALF_DIV_TB));
        check(13'(riseSeen), 13'(FRAME_CLOCKS));
        check({12'h000, standby}, 13'h0001);
    endtask
    initial begin
        repeat (8) @(posedge clk);
        #2; rst = 1'b0;
        for (int i = 0; i < 9; i++) convert(i[0], i[2:0], samples[i]);
        // abort mid-acquisition, then a clean frame must follow
        startReq = 1'b1;
        for (int n = 0; n < 100 && sampling !== 1'b1; n++) @(posedge clk);
        #2;
        check({12'h000, sampling}, 13'h0001);
        rst = 1'b1;
        startReq = 1'b0;
        @(posedge clk); #2;
        check({12'h000, standby}, 13'h0001);
        check({12'h000, link.sdoEn}, 13'h0000);
        rst = 1'b0;
        convert(1'b1, 3'h5, -2);
        close_out();
    end
    initial begin
        #400000;
        err_total++;
        close_out();
    end
endmodule
